// ==== src/wrr_cfg.svh ====
// Offsets, field positions, reset values and sizes for the WRR queue scheduler.
// Assumes byte addresses on a 12-bit register port with 32-bit words.
`ifndef WRR_CFG_SVH
`define WRR_CFG_SVH

`define WRR_ADDR_W 12
`define WRR_NUM_WORDS 4
`define WRR_NUM_SLOTS 16
`define WRR_SLOT_W 8
`define WRR_QPTR_LSB 0
`define WRR_CNT_LSB 4
`define WRR_FIELD_W 4

`define WRR_OFS_WORD0 12'h7E0
`define WRR_OFS_WORD1 12'h7E4
`define WRR_OFS_WORD2 12'h7E8
`define WRR_OFS_WORD3 12'h7EC
`define WRR_OFS_CTRL 12'h7F0
`define WRR_OFS_STAT 12'h7F4

`define WRR_RST_WORD0 32'h03020100
`define WRR_RST_WORD1 32'h07060504
`define WRR_RST_WORD2 32'h0B0A0908
`define WRR_RST_WORD3 32'h0F0E0D0C
`define WRR_RST_CTRL 32'h00000000

`define WRR_CTRL_EN_BIT 0
`define WRR_CTRL_RESTART_BIT 1
`define WRR_STAT_SLOT_LSB 0
`define WRR_STAT_DONE_LSB 4
`define WRR_STAT_QPTR_LSB 8
`define WRR_STAT_CNT_LSB 12
`define WRR_STAT_RUN_BIT 16

`endif

// ==== src/wrr_pkg.sv ====
// Types shared by the WRR queue scheduler files.
// Assumes wrr_cfg.svh is on the include path.
`include "wrr_cfg.svh"

package wrr_pkg;
  // One schedule slot: count-minus-one above, queue pointer below
  typedef struct packed {
    logic [`WRR_FIELD_W-1:0] cnt;
    logic [`WRR_FIELD_W-1:0] qptr;
  } wrr_slot_t;

  typedef logic [`WRR_NUM_WORDS-1:0][31:0] wrr_words_t;

  typedef enum logic [0:0] {
    WRR_ST_IDLE = 1'b0,
    WRR_ST_RUN = 1'b1
  } wrr_state_t;

  // Current schedule position toward the descriptor fetch logic
  typedef struct packed {
    logic [`WRR_FIELD_W-1:0] slot;
    logic [`WRR_FIELD_W-1:0] qptr;
    logic [`WRR_FIELD_W-1:0] cnt;
  } wrr_sel_t;
endpackage

// ==== src/wrr_slot_pick.sv ====
// Extracts one schedule slot from the packed schedule words.
// Assumes four slots per 32-bit word, slot 0 in the low byte of word 0.
`timescale 1ns/1ps
`default_nettype none
`include "wrr_cfg.svh"

module wrr_slot_pick
  import wrr_pkg::*;
(
  input wire wrr_words_t words_in,
  input wire logic [`WRR_FIELD_W-1:0] slot_in,
  output wrr_slot_t slot_out
);

  logic [31:0] word;

  always_comb begin
    word = words_in[slot_in[3:2]];
    slot_out = wrr_slot_t'(word[{slot_in[1:0], 3'h0} +: `WRR_SLOT_W]);
  end

endmodule

`default_nettype wire

// ==== src/wrr_sched.sv ====
// Weighted round-robin scheduler over sixteen transmit descriptor queues.
// Assumes a single clock, a plain register port and one-cycle done pulses.
//
// What this block does
// - Slot 0 queue pointer in word 0 bits 3-0
// - Count field means count minus one messages
// - Slot 0 count bits 7-4, then slot 1
// - Slot 1 uses bits 11-8 and 15-12
// - Slot 2 uses bits 19-16 and 23-20
// - Slot 3 uses bits 27-24 and 31-28
// - Slot 4 uses word 1 bits 3-0, 7-4
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wrr_cfg.svh"

module wrr_sched
  import wrr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  input wire logic [`WRR_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic MSG_DONE_IN,
  output logic VALID_OUT,
  output logic [`WRR_FIELD_W-1:0] QUEUE_SEL_OUT,
  output logic [`WRR_FIELD_W-1:0] MSG_COUNT_OUT,
  output logic [`WRR_FIELD_W-1:0] SLOT_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_n_reg;

  // Async assert, sync release
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [`WRR_ADDR_W-1:0] word_ofs(input int idx);
    logic [`WRR_ADDR_W-1:0] ofs;
    case (idx)
      0: ofs = `WRR_OFS_WORD0;
      1: ofs = `WRR_OFS_WORD1;
      2: ofs = `WRR_OFS_WORD2;
      default: ofs = `WRR_OFS_WORD3;
    endcase
    return ofs;
  endfunction

  function automatic logic [31:0] word_rst(input int idx);
    logic [31:0] val;
    case (idx)
      0: val = `WRR_RST_WORD0;
      1: val = `WRR_RST_WORD1;
      2: val = `WRR_RST_WORD2;
      default: val = `WRR_RST_WORD3;
    endcase
    return val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Schedule words

  wrr_words_t words_reg;
  wrr_words_t words_next;

  genvar gi;
  generate
    for (gi = 0; gi < `WRR_NUM_WORDS; gi++) begin : g_word
      always_comb begin
        words_next[gi] = words_reg[gi];
        if (WR_IN && (ADDR_IN == word_ofs(gi))) begin
          words_next[gi] = WDATA_IN;
        end
      end

      always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          words_reg[gi] <= word_rst(gi);
        end else if (CE_IN) begin
          words_reg[gi] <= words_next[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Only the enable bit of the control word is stored
  localparam logic [31:0] ctrl_rst = `WRR_RST_CTRL;

  logic enable_reg;
  logic enable_next;
  logic restart;

  always_comb begin
    enable_next = enable_reg;
    restart = 1'b0;
    if (WR_IN && (ADDR_IN == `WRR_OFS_CTRL)) begin
      enable_next = WDATA_IN[`WRR_CTRL_EN_BIT];
      restart = WDATA_IN[`WRR_CTRL_RESTART_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      enable_reg <= ctrl_rst[`WRR_CTRL_EN_BIT];
    end else if (CE_IN) begin
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler state

  wrr_state_t state_reg;
  wrr_state_t state_next;
  logic [`WRR_FIELD_W-1:0] slot_reg;
  logic [`WRR_FIELD_W-1:0] slot_next;
  logic [`WRR_FIELD_W-1:0] done_reg;
  logic [`WRR_FIELD_W-1:0] done_next;
  wrr_slot_t cur_reg;
  wrr_slot_t cur_next;

  // Fields of the slot being entered, so outputs never lag the position
  wrr_slot_pick u_pick (
    .words_in(words_reg),
    .slot_in(slot_next),
    .slot_out(cur_next)
  );

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    done_next = done_reg;
    case (state_reg)
      WRR_ST_IDLE: begin
        slot_next = '0;
        done_next = '0;
        if (enable_reg) begin
          state_next = WRR_ST_RUN;
        end
      end
      WRR_ST_RUN: begin
        if (!enable_reg || restart) begin
          state_next = enable_reg ? WRR_ST_RUN : WRR_ST_IDLE;
          slot_next = '0;
          done_next = '0;
        end else if (MSG_DONE_IN) begin
          // Compare with >= so a count lowered mid-slot cannot overrun
          if (done_reg >= cur_reg.cnt) begin
            slot_next = slot_reg + 4'h1;
            done_next = '0;
          end else begin
            done_next = done_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = WRR_ST_IDLE;
        slot_next = '0;
        done_next = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= WRR_ST_IDLE;
      slot_reg <= '0;
      done_reg <= '0;
      cur_reg <= '0;
    end else if (CE_IN) begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      done_reg <= done_next;
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h00000000;
    if (RD_IN) begin
      if (ADDR_IN == `WRR_OFS_WORD0) begin
        rdata_next = words_reg[0];
      end else if (ADDR_IN == `WRR_OFS_WORD1) begin
        rdata_next = words_reg[1];
      end else if (ADDR_IN == `WRR_OFS_WORD2) begin
        rdata_next = words_reg[2];
      end else if (ADDR_IN == `WRR_OFS_WORD3) begin
        rdata_next = words_reg[3];
      end else if (ADDR_IN == `WRR_OFS_CTRL) begin
        rdata_next[`WRR_CTRL_EN_BIT] = enable_reg;
      end else if (ADDR_IN == `WRR_OFS_STAT) begin
        rdata_next[`WRR_STAT_SLOT_LSB +: `WRR_FIELD_W] = slot_reg;
        rdata_next[`WRR_STAT_DONE_LSB +: `WRR_FIELD_W] = done_reg;
        rdata_next[`WRR_STAT_QPTR_LSB +: `WRR_FIELD_W] = cur_reg.qptr;
        rdata_next[`WRR_STAT_CNT_LSB +: `WRR_FIELD_W] = cur_reg.cnt;
        rdata_next[`WRR_STAT_RUN_BIT] = (state_reg == WRR_ST_RUN);
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 32'h00000000;
    end else if (CE_IN) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA_OUT = rdata_reg;
  assign VALID_OUT = (state_reg == WRR_ST_RUN);
  assign QUEUE_SEL_OUT = cur_reg.qptr;
  assign MSG_COUNT_OUT = cur_reg.cnt;
  assign SLOT_OUT = slot_reg;

endmodule

`default_nettype wire

// ==== tb/wrr_sched_sva.sv ====
// Port checker for wrr_sched, bound into every instance.
// Assumes words are only written at aligned offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wrr_cfg.svh"

module wrr_sched_sva
  import wrr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  input wire logic [`WRR_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic MSG_DONE_IN,
  input wire logic VALID_OUT,
  input wire logic [3:0] QUEUE_SEL_OUT,
  input wire logic [3:0] MSG_COUNT_OUT,
  input wire logic [3:0] SLOT_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wrr_words_t sh_reg;
  logic [1:0] wr_reg;
  logic [3:0] dcnt_reg;
  wire logic wr_ok = CE_IN && WR_IN;
  // Two-cycle guard: outputs lag schedule writes by one cycle
  wire logic settled = VALID_OUT && wr_reg == 2'h0;
  wire logic adv = settled && CE_IN && MSG_DONE_IN && !WR_IN && dcnt_reg >= MSG_COUNT_OUT;
  wire logic [7:0] cur = {MSG_COUNT_OUT, QUEUE_SEL_OUT};
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sh_reg <= {`WRR_RST_WORD3, `WRR_RST_WORD2, `WRR_RST_WORD1, `WRR_RST_WORD0};
      wr_reg <= 2'h0;
      dcnt_reg <= 4'h0;
    end else begin
      wr_reg <= {wr_reg[0], wr_ok};
      if (wr_ok && ADDR_IN[11:4] == 8'h7E) begin
        sh_reg[ADDR_IN[3:2]] <= WDATA_IN;
      end
      // Idle or a restart write clears the count; a plain enable rewrite keeps it
      if (!VALID_OUT || (wr_ok && ADDR_IN == `WRR_OFS_CTRL &&
          WDATA_IN[`WRR_CTRL_RESTART_BIT])) begin
        dcnt_reg <= 4'h0;
      end else if (CE_IN && MSG_DONE_IN) begin
        dcnt_reg <= (dcnt_reg >= MSG_COUNT_OUT) ? 4'h0 : dcnt_reg + 4'h1;
      end
    end
  end
  ////////////////////////////////////////
  property p_s0q; settled && SLOT_OUT == 4'h0 |-> QUEUE_SEL_OUT == sh_reg[0][3:0]; endproperty
  a_s0q: assert property (p_s0q) else $error("slot 0 queue wrong");
  property p_s0c; settled && SLOT_OUT == 4'h0 |-> MSG_COUNT_OUT == sh_reg[0][7:4]; endproperty
  a_s0c: assert property (p_s0c) else $error("slot 0 count wrong");
  property p_s1; settled && SLOT_OUT == 4'h1 |-> cur == sh_reg[0][15:8]; endproperty
  a_s1: assert property (p_s1) else $error("slot 1 fields wrong");
  property p_s2; settled && SLOT_OUT == 4'h2 |-> cur == sh_reg[0][23:16]; endproperty
  a_s2: assert property (p_s2) else $error("slot 2 fields wrong");
  property p_s3; settled && SLOT_OUT == 4'h3 |-> cur == sh_reg[0][31:24]; endproperty
  a_s3: assert property (p_s3) else $error("slot 3 fields wrong");
  property p_s4; settled && SLOT_OUT == 4'h4 |-> cur == sh_reg[1][7:0]; endproperty
  a_s4: assert property (p_s4) else $error("slot 4 fields wrong");
  property p_adv; adv |=> VALID_OUT && SLOT_OUT == $past(SLOT_OUT) + 4'h1; endproperty
  a_adv: assert property (p_adv) else $error("slot did not advance");
  property p_wrap; adv && SLOT_OUT == 4'hF |=> SLOT_OUT == 4'h0; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to slot 0");
  c_adv: cover property (adv && MSG_COUNT_OUT == 4'hF);
  c_s4: cover property (settled && SLOT_OUT == 4'h4);
  c_wrap: cover property (adv && SLOT_OUT == 4'hF);
endmodule

bind wrr_sched wrr_sched_sva i_wrr_sched_sva (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .CE_IN(CE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
  .MSG_DONE_IN(MSG_DONE_IN), .VALID_OUT(VALID_OUT), .QUEUE_SEL_OUT(QUEUE_SEL_OUT),
  .MSG_COUNT_OUT(MSG_COUNT_OUT), .SLOT_OUT(SLOT_OUT));
`default_nettype wire

// ==== tb/wrr_engine_model.sv ====
// Message engine model: one done pulse per handled message.
// Assumes it works only while the scheduler shows a valid queue.
`timescale 1ns/1ps
`default_nettype none

module wrr_engine_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire logic [1:0] gap_in,
  output logic done_out
);
  logic [1:0] wait_reg;
  // Gap 0 gives a done every cycle, the harshest load
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= valid_in && wait_reg == 2'h0;
      wait_reg <= (valid_in && wait_reg != 2'h0) ? wait_reg - 2'h1 : gap_in;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for wrr_sched with a message engine model.
// Assumes package and config header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wrr_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, eng_en = 1'b0, ce = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h00000057;
  logic [31:0] w [4];
  logic [1:0] gap = 2'h0;
  logic done, valid;
  logic [3:0] qsel, mcnt, slot, es, d;
  logic [7:0] f;
  int n_fail = 0, checked = 0;
  always #10 clk = ~clk;
  wrr_sched i_wrr_sched (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .MSG_DONE_IN(done),
    .VALID_OUT(valid), .QUEUE_SEL_OUT(qsel), .MSG_COUNT_OUT(mcnt), .SLOT_OUT(slot));
  wrr_engine_model i_wrr_engine_model (.clk_in(clk), .rst_n_in(rst_n),
    .valid_in(valid && eng_en), .gap_in(gap), .done_out(done));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] fld(input logic [3:0] s);
    return w[s[3:2]][{s[1:0], 3'b000} +: 8];
  endfunction
  ////////////////////////////////////////
  always @(posedge clk) begin
    f = fld(es);
    if (valid !== 1'b1) begin
      es = 4'h0;
      d = 4'h0;
    end else if (ce === 1'b1 && wr === 1'b1 && addr == `WRR_OFS_CTRL &&
        wdata[`WRR_CTRL_RESTART_BIT] === 1'b1) begin
      // Restart jumps to slot 0 and drops the done pulse of that cycle
      es = 4'h0;
      d = 4'h0;
    end else if (done === 1'b1 && ce === 1'b1) begin
      d = (d == f[7:4]) ? 4'h0 : d + 4'h1;
      es = (d == 4'h0) ? es + 4'h1 : es;
    end
  end
  always @(negedge clk) begin
    if (valid === 1'b1) begin
      `CHK(slot, es)
      `CHK({mcnt, qsel}, fld(es))
    end
  end
  task automatic put(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Words never change mid-run, so the one-cycle write lag stays out
  task automatic run(input logic [1:0] g, input int n);
    for (int i = 0; i < 4; i++) begin
      put(12'h7E0 + 12'(4 * i), w[i]);
    end
    get(12'h7E4, w[1]);
    gap <= g;
    eng_en <= 1'b1;
    put(12'h7F0, 32'h00000001);
    repeat (3) @(posedge clk);
    #1;
    `CHK(valid, 1'b1)
    repeat (n / 2) @(posedge clk);
    // Frozen state must ignore done pulses
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    put(`WRR_OFS_CTRL, 32'h00000003);
    repeat (n / 2) @(posedge clk);
    eng_en <= 1'b0;
    repeat (4) @(posedge clk);
    put(12'h7F0, 32'h00000000);
    repeat (3) @(posedge clk);
    get(`WRR_OFS_CTRL, 32'h00000000);
    get(`WRR_OFS_STAT, {16'h0000, w[0][7:0], 8'h00});
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    get(12'h7E0, `WRR_RST_WORD0);
    get(12'h7E4, `WRR_RST_WORD1);
    get(12'h7F8, 32'h00000000);
    w = '{default: 32'h00000000};
    run(2'h0, 40);
    w = '{default: 32'hFFFFFFFF};
    run(2'h0, 300);
    repeat (4) begin
      for (int i = 0; i < 4; i++) begin
        repeat (9) seed = lfsr(seed);
        w[i] = seed;
      end
      run(seed[1:0], 200);
    end
    give_verdict();
  end
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
